// ### hdl/nco_map.vh
`ifndef NCO_MAP_VH
`define NCO_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_CONTROL     8'h00
`define OFS_CLOCK_CTRL  8'h04
`define OFS_ACC_LOW     8'h08
`define OFS_ACC_HIGH    8'h0C
`define OFS_ACC_UPPER   8'h10
`define OFS_INC_LOW     8'h14
`define OFS_INC_HIGH    8'h18
`define OFS_INC_UPPER   8'h1C
`define OFS_IRQ_REQ     8'h20
`define OFS_IRQ_EN      8'h24
`define OFS_IRQ_GLOBAL  8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ENABLE      7
`define BIT_OUT         5
`define BIT_INVERT      4
`define BIT_PFM         0
`define FLD_PWS_HI      7
`define FLD_PWS_LO      5
`define FLD_CKS_HI      2
`define FLD_CKS_LO      0
`define BIT_PIN_ROUTE   1
`define BIT_PERIPH_EN   0
`define BIT_GLOBAL_EN   1

// ----------------------------------------------------------------
// Clock source codes and timing
// ----------------------------------------------------------------
`define CKS_SYSTEM      3'h0
`define CKS_HFOSC       3'h1
`define CKS_LOGIC_ONE   3'h2
`define CKS_LOGIC_FOUR  3'h5
`define INC_LOAD_EDGES  2'h2
`define RESET_ZERO      8'h00

`endif

// ### hdl/numerically_controlled_oscillator.v
// Functional notes
// - Accumulator adds buffered increment each input edge
// - Twenty-bit accumulator, three byte registers
// - Carry out is the raw overflow
// - Twenty-bit increment in low/high/upper bytes
// - Enabled: low write loads buffer second edge
// - Disabled: buffer loads on the next core clock after any increment byte write
// - Increment buffer hidden from software
// - Fixed duty mode toggles on overflow
// - Pulse mode: active pulse after overflow
// - Pulse width from three-bit select field
// - Polarity bit inverts shaped output
// - Polarity change raises interrupt when enabled
// - Overflow sets interrupt flag
// - Interrupt needs four enables set
// - Reset clears every register
// - Runs on core clock; other sources synchronised to it
// - Keep internal oscillator awake when selected and enabled
// - Three-bit source select, six sources
// - Combinational full adder, clocked update
// - Output to peripherals and pin
// - Width codes are powers of two
// - Source code decode, two reserved
`timescale 1ns/1ps
`include "nco_map.vh"

module numerically_controlled_oscillator #(
	parameter ACC_WIDTH = 20
)(
	input  wire        core_clk_in,
	input  wire        reset_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output wire        pready_out,
	output reg         pslverr_out,
	input  wire        internal_hf_oscillator_in,
	input  wire [3:0]  config_logic_out_in,
	output wire        synth_output_out,
	output wire        synth_pin_out,
	output wire        accumulator_carry_out,
	output wire        irq_out,
	output wire        hf_oscillator_keep_awake_out
);

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	reg                  oscillator_enable_q;
	reg                  output_invert_q;
	reg                  pulse_frequency_mode_select_q;
	reg                  pin_route_q;
	reg  [2:0]           pulse_width_select_q;
	reg  [2:0]           clock_source_select_q;
	reg  [ACC_WIDTH-1:0] acc_q;
	reg  [ACC_WIDTH-1:0] inc_front_q;
	reg  [ACC_WIDTH-1:0] inc_buf_q;
	reg                  overflow_irq_flag_q;
	reg                  overflow_irq_enable_q;
	reg                  peripheral_irq_enable_q;
	reg                  global_irq_enable_q;
	reg                  load_now_q;
	reg  [1:0]           load_edges_q;
	reg                  shaped_q;
	reg  [7:0]           pulse_left_q;
	reg                  carry_q;
	reg  [5:0]           sync1_q;
	reg  [5:0]           sync2_q;
	reg  [5:0]           sync3_q;
	// Next values and registered outputs
	reg                  shaped_d;
	reg  [7:0]           pulse_left_d;
	reg                  synth_q;
	reg                  synth_pin_q;
	reg                  irq_q;
	reg                  keep_awake_q;

	wire setup_phase = psel_in & ~penable_in;
	wire wr          = psel_in & penable_in & pwrite_in;
	wire rd_unmapped = ~addr_mapped(paddr_in);

	assign pready_out = 1'b1;

	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a[1:0] == 2'h0) && (a <= `OFS_IRQ_GLOBAL);
		end
	endfunction

	function is_write;
		input       w;
		input [7:0] a;
		input [7:0] ofs;
		begin
			is_write = w && (a == ofs);
		end
	endfunction

	// ------------------------------------------------------------
	// Input clock selection
	// ------------------------------------------------------------
	// Asynchronous sources are synchronised, then edge detected
	wire [5:0] src_raw = {config_logic_out_in, internal_hf_oscillator_in, 1'b0};
	wire [5:0] src_rise = sync2_q & ~sync3_q;
	reg        tick;

	always @*
	begin
		case (clock_source_select_q)
			`CKS_SYSTEM: tick = 1'b1;
			3'h1:        tick = src_rise[1];
			3'h2:        tick = src_rise[2];
			3'h3:        tick = src_rise[3];
			3'h4:        tick = src_rise[4];
			3'h5:        tick = src_rise[5];
			default:     tick = 1'b0;
		endcase
	end

	always @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			sync3_q <= 6'h00;
		end
		else
		begin
			sync1_q <= src_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign hf_oscillator_keep_awake_out = keep_awake_q;

	// ------------------------------------------------------------
	// Adder and overflow
	// ------------------------------------------------------------
	wire [ACC_WIDTH:0] sum = {1'b0, acc_q} + {1'b0, inc_buf_q};
	wire run      = oscillator_enable_q & tick;
	wire overflow = run & sum[ACC_WIDTH];
	wire [7:0] width_cycles = 8'h01 << pulse_width_select_q;

	assign accumulator_carry_out = carry_q;

	// ------------------------------------------------------------
	// Output shaping
	// ------------------------------------------------------------
	// Registered outputs come from next values, so that they change
	// in the same cycle as the registers that they follow
	wire       ctrl_wr                 = is_write(wr, paddr_in, `OFS_CONTROL);
	wire       clk_ctrl_wr             = is_write(wr, paddr_in, `OFS_CLOCK_CTRL);
	wire       irq_en_wr               = is_write(wr, paddr_in, `OFS_IRQ_EN);
	wire       irq_glob_wr             = is_write(wr, paddr_in, `OFS_IRQ_GLOBAL);
	wire       oscillator_enable_d     = ctrl_wr ?
		pwdata_in[`BIT_ENABLE] : oscillator_enable_q;
	wire       output_invert_d         = ctrl_wr ?
		pwdata_in[`BIT_INVERT] : output_invert_q;
	wire       pin_route_d             = ctrl_wr ?
		pwdata_in[`BIT_PIN_ROUTE] : pin_route_q;
	wire [2:0] clock_source_select_d   = clk_ctrl_wr ?
		pwdata_in[`FLD_CKS_HI:`FLD_CKS_LO] : clock_source_select_q;
	wire       overflow_irq_enable_d   = irq_en_wr ?
		pwdata_in[0] : overflow_irq_enable_q;
	wire       peripheral_irq_enable_d = irq_glob_wr ?
		pwdata_in[`BIT_PERIPH_EN] : peripheral_irq_enable_q;
	wire       global_irq_enable_d     = irq_glob_wr ?
		pwdata_in[`BIT_GLOBAL_EN] : global_irq_enable_q;
	wire       invert_change           = ctrl_wr &&
		(pwdata_in[`BIT_INVERT] != output_invert_q);
	wire       flag_set                = overflow |
		(invert_change & overflow_irq_enable_q);
	wire       flag_clear              = is_write(wr, paddr_in, `OFS_IRQ_REQ) && !pwdata_in[0];
	wire       overflow_irq_flag_d     = flag_set | (overflow_irq_flag_q & ~flag_clear);
	wire       synth_d                 = shaped_d ^ output_invert_d;

	assign synth_output_out = synth_q;
	assign synth_pin_out    = synth_pin_q;
	assign irq_out          = irq_q;

	// Pulse mode counts input ticks down; a new overflow restarts the pulse
	always @*
	begin
		shaped_d     = shaped_q;
		pulse_left_d = pulse_left_q;
		if (!oscillator_enable_q)
		begin
			shaped_d     = 1'b0;
			pulse_left_d = `RESET_ZERO;
		end
		else if (!pulse_frequency_mode_select_q)
		begin
			pulse_left_d = `RESET_ZERO;
			if (overflow)
				shaped_d = ~shaped_q;
		end
		else if (overflow)
		begin
			shaped_d     = 1'b1;
			pulse_left_d = width_cycles - 8'h01;
		end
		else if (tick && shaped_q)
		begin
			if (pulse_left_q == 8'h00)
				shaped_d = 1'b0;
			else
				pulse_left_d = pulse_left_q - 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Shaping and output registers
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			shaped_q     <= 1'b0;
			pulse_left_q <= `RESET_ZERO;
			carry_q      <= 1'b0;
			synth_q      <= 1'b0;
			synth_pin_q  <= 1'b0;
			irq_q        <= 1'b0;
			keep_awake_q <= 1'b0;
		end
		else
		begin
			shaped_q     <= shaped_d;
			pulse_left_q <= pulse_left_d;
			carry_q      <= overflow;
			synth_q      <= synth_d;
			synth_pin_q  <= synth_d & pin_route_d;
			irq_q        <= overflow_irq_flag_d & overflow_irq_enable_d &
				oscillator_enable_d & peripheral_irq_enable_d & global_irq_enable_d;
			keep_awake_q <= oscillator_enable_d &&
				(clock_source_select_d == `CKS_HFOSC);
		end
	end

	// ------------------------------------------------------------
	// Accumulator and increment buffer
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			acc_q        <= {ACC_WIDTH{1'b0}};
			inc_buf_q    <= {ACC_WIDTH{1'b0}};
			load_now_q   <= 1'b0;
			load_edges_q <= 2'h0;
		end
		else
		begin
			if (is_write(wr, paddr_in, `OFS_ACC_LOW))
				acc_q[7:0] <= pwdata_in[7:0];
			else if (is_write(wr, paddr_in, `OFS_ACC_HIGH))
				acc_q[15:8] <= pwdata_in[7:0];
			else if (is_write(wr, paddr_in, `OFS_ACC_UPPER))
				acc_q[ACC_WIDTH-1:16] <= pwdata_in[ACC_WIDTH-17:0];
			else if (run)
				acc_q <= sum[ACC_WIDTH-1:0];

			load_now_q <= 1'b0;
			if (wr && !oscillator_enable_q &&
				(paddr_in == `OFS_INC_LOW || paddr_in == `OFS_INC_HIGH ||
				paddr_in == `OFS_INC_UPPER))
				load_now_q <= 1'b1;
			if (load_now_q)
				inc_buf_q <= inc_front_q;

			if (is_write(wr, paddr_in, `OFS_INC_LOW) && oscillator_enable_q)
				load_edges_q <= `INC_LOAD_EDGES;
			else if (tick && load_edges_q != 2'h0)
			begin
				load_edges_q <= load_edges_q - 2'h1;
				if (load_edges_q == 2'h1)
					inc_buf_q <= inc_front_q;
			end
		end
	end

	// ------------------------------------------------------------
	// APB writes
	// ------------------------------------------------------------
	always @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			oscillator_enable_q           <= 1'b0;
			output_invert_q               <= 1'b0;
			pulse_frequency_mode_select_q <= 1'b0;
			pin_route_q                   <= 1'b0;
			pulse_width_select_q          <= 3'h0;
			clock_source_select_q         <= 3'h0;
			inc_front_q                   <= {ACC_WIDTH{1'b0}};
			overflow_irq_flag_q           <= 1'b0;
			overflow_irq_enable_q         <= 1'b0;
			peripheral_irq_enable_q       <= 1'b0;
			global_irq_enable_q           <= 1'b0;
		end
		else
		begin
			if (is_write(wr, paddr_in, `OFS_CONTROL))
			begin
				oscillator_enable_q           <= pwdata_in[`BIT_ENABLE];
				output_invert_q               <= pwdata_in[`BIT_INVERT];
				pulse_frequency_mode_select_q <= pwdata_in[`BIT_PFM];
				pin_route_q                   <= pwdata_in[`BIT_PIN_ROUTE];
			end
			if (is_write(wr, paddr_in, `OFS_CLOCK_CTRL))
			begin
				pulse_width_select_q  <= pwdata_in[`FLD_PWS_HI:`FLD_PWS_LO];
				clock_source_select_q <= pwdata_in[`FLD_CKS_HI:`FLD_CKS_LO];
			end
			if (is_write(wr, paddr_in, `OFS_INC_LOW))
				inc_front_q[7:0] <= pwdata_in[7:0];
			if (is_write(wr, paddr_in, `OFS_INC_HIGH))
				inc_front_q[15:8] <= pwdata_in[7:0];
			if (is_write(wr, paddr_in, `OFS_INC_UPPER))
				inc_front_q[ACC_WIDTH-1:16] <= pwdata_in[ACC_WIDTH-17:0];
			if (flag_set)
				overflow_irq_flag_q <= 1'b1;
			else if (flag_clear)
				overflow_irq_flag_q <= 1'b0;
			if (is_write(wr, paddr_in, `OFS_IRQ_EN))
				overflow_irq_enable_q <= pwdata_in[0];
			if (is_write(wr, paddr_in, `OFS_IRQ_GLOBAL))
			begin
				peripheral_irq_enable_q <= pwdata_in[`BIT_PERIPH_EN];
				global_irq_enable_q     <= pwdata_in[`BIT_GLOBAL_EN];
			end
		end
	end

	// ------------------------------------------------------------
	// APB reads, captured in the setup cycle
	// ------------------------------------------------------------
	reg [7:0] rd_byte;

	always @*
	begin
		rd_byte = 8'h00;
		case (paddr_in)
			`OFS_CONTROL:    rd_byte = {oscillator_enable_q, 1'b0, synth_q,
				output_invert_q, 2'b00, pin_route_q, pulse_frequency_mode_select_q};
			`OFS_CLOCK_CTRL: rd_byte = {pulse_width_select_q, 2'b00, clock_source_select_q};
			`OFS_ACC_LOW:    rd_byte = acc_q[7:0];
			`OFS_ACC_HIGH:   rd_byte = acc_q[15:8];
			`OFS_ACC_UPPER:  rd_byte = {4'h0, acc_q[ACC_WIDTH-1:16]};
			`OFS_INC_LOW:    rd_byte = inc_front_q[7:0];
			`OFS_INC_HIGH:   rd_byte = inc_front_q[15:8];
			`OFS_INC_UPPER:  rd_byte = {4'h0, inc_front_q[ACC_WIDTH-1:16]};
			`OFS_IRQ_REQ:    rd_byte = {7'h00, overflow_irq_flag_q};
			`OFS_IRQ_EN:     rd_byte = {7'h00, overflow_irq_enable_q};
			`OFS_IRQ_GLOBAL: rd_byte = {6'h00, global_irq_enable_q, peripheral_irq_enable_q};
			default:         rd_byte = 8'h00;
		endcase
	end

	always @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata_out  <= {24'h000000, rd_byte};
			pslverr_out <= rd_unmapped;
		end
	end

endmodule // numerically_controlled_oscillator

// ### tb/nco_monitor.sv
`timescale 1ns/1ps
module nco_monitor (
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        synth_output_out,
	input wire logic        synth_pin_out,
	input wire logic        accumulator_carry_out,
	input wire logic        irq_out,
	input wire logic        hf_oscillator_keep_awake_out
);
	logic wr_acc;
	logic bad_addr;
	assign wr_acc = psel_in && penable_in && pwrite_in;
	assign bad_addr = (paddr_in > 8'h28) || (paddr_in[1:0] != 2'h0);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);
	a_ready_high: assert property (pready_out)
		else $error("pready low");
	a_pin_gated: assert property (synth_pin_out |-> synth_output_out)
		else $error("pin without output");
	a_reset_quiet: assert property ($fell(reset_in) |-> !irq_out && !synth_output_out
		&& !hf_oscillator_keep_awake_out) else $error("outputs after reset");
	a_addr_refused: assert property (psel_in && penable_in |-> pslverr_out == bad_addr)
		else $error("slave error wrong");
	a_read_bytes: assert property (psel_in && penable_in && !pwrite_in
		|-> prdata_out[31:8] == 24'h0) else $error("upper read bits set");
	a_flag_sticky: assert property (irq_out && !wr_acc |=> irq_out)
		else $error("irq dropped without write");
	a_irq_cause: assert property ($rose(irq_out) |-> ($past(wr_acc) ||
		$past(accumulator_carry_out) || accumulator_carry_out) or (##1 accumulator_carry_out))
		else $error("irq without cause");
	a_awake_by_write: assert property ($changed(hf_oscillator_keep_awake_out)
		|-> $past(wr_acc)) else $error("keep awake moved alone");
	c_carry: cover property (accumulator_carry_out);
	c_irq: cover property (irq_out);
	c_refused: cover property (psel_in && penable_in && pslverr_out);
endmodule // nco_monitor

// ### tb/nco_peripheral_model.sv
`timescale 1ns/1ps
module nco_peripheral_model (
	input  wire logic   core_clk_in,
	input  wire logic   clear_in,
	input  wire logic   synth_in,
	input  wire logic   carry_in,
	output logic        hf_clk_out,
	output logic [3:0]  logic_clk_out,
	output logic [31:0] high_cnt_out,
	output logic [31:0] carry_cnt_out
);
	// Free-running sources, phase unrelated to the core clock
	initial
	begin
		hf_clk_out = 1'b0;
		#7;
		forever #80 hf_clk_out = ~hf_clk_out;
	end
	for (genvar i = 0; i < 4; i++)
	begin : g_src
		initial
		begin
			logic_clk_out[i] = 1'b0;
			#(3 + 11 * i);
			forever #(40 * (i + 2)) logic_clk_out[i] = ~logic_clk_out[i];
		end
	end
	always @(posedge core_clk_in)
	begin
		high_cnt_out <= clear_in ? 32'h0 : high_cnt_out + synth_in;
		carry_cnt_out <= clear_in ? 32'h0 : carry_cnt_out + carry_in;
	end
endmodule // nco_peripheral_model

// ### tb/tb_numerically_controlled_oscillator.sv
`timescale 1ns/1ps
`include "nco_map.vh"
module tb_numerically_controlled_oscillator;
	logic        core_clk_in, reset_in, psel_in, penable_in, pwrite_in, clear, err;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in, rdata, high_cnt, carry_cnt;
	wire  [31:0] prdata_out;
	wire         pready_out, pslverr_out, synth_output_out, synth_pin_out, irq_out;
	wire         accumulator_carry_out, hf_oscillator_keep_awake_out, hf_clk;
	wire  [3:0]  logic_clk;
	int          miscompares, total_checks;
	logic [7:0]  rw_ofs[6] = '{`OFS_ACC_UPPER, `OFS_ACC_HIGH, `OFS_ACC_LOW,
		`OFS_INC_UPPER, `OFS_INC_HIGH, `OFS_INC_LOW};
	logic [7:0]  rw_dat[6] = '{8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hAB, 8'hCD};
	logic [7:0]  rw_exp[6] = '{8'h0F, 8'hA5, 8'h5A, 8'h0F, 8'hAB, 8'hCD};
	int          rate_exp[8] = '{120, 30, 30, 20, 15, 12, 0, 0};
	numerically_controlled_oscillator numerically_controlled_oscillator_i (
		.core_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out, .internal_hf_oscillator_in(hf_clk),
		.config_logic_out_in(logic_clk), .synth_output_out, .synth_pin_out,
		.accumulator_carry_out, .irq_out, .hf_oscillator_keep_awake_out);
	nco_peripheral_model nco_peripheral_model_i (.core_clk_in, .clear_in(clear),
		.synth_in(synth_output_out), .carry_in(accumulator_carry_out), .hf_clk_out(hf_clk),
		.logic_clk_out(logic_clk), .high_cnt_out(high_cnt), .carry_cnt_out(carry_cnt));
	initial
	begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	task check(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task near(input string name, input logic [31:0] got, input int exp, input int tol);
		check(name, (got + tol >= exp && got <= exp + tol) ? exp : got, exp);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		@(posedge core_clk_in);
		while (pready_out !== 1'b1) @(posedge core_clk_in);
		rdata = prdata_out;
		err = pslverr_out;
		{psel_in, penable_in} <= 2'b00;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rdata, {24'h0, e});
	endtask
	task set_inc(input logic [19:0] v);
		wr(`OFS_INC_UPPER, {4'h0, v[19:16]});
		wr(`OFS_INC_HIGH, v[15:8]);
		wr(`OFS_INC_LOW, v[7:0]);
	endtask
	task run(input int n);
		clear <= 1'b1;
		@(posedge core_clk_in);
		clear <= 1'b0;
		repeat (n) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	task irq_is(input logic e);
		@(negedge core_clk_in);
		check("irq", {31'h0, irq_out}, {31'h0, e});
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#1000000;
		miscompares++;
		stop_test();
	end
	initial
	begin
		{psel_in, penable_in, pwrite_in, clear, paddr_in, pwdata_in} = '0;
		reset_in = 1'b1;
		repeat (16) @(posedge core_clk_in);
		reset_in <= 1'b0;
		for (int a = 0; a <= 'h28; a += 4) rd(a[7:0], 8'h00);
		rd(8'h2C, 8'h00);
		check("slverr", {31'h0, err}, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			wr(rw_ofs[i], rw_dat[i]);
			rd(rw_ofs[i], rw_exp[i]);
		end
		set_inc(20'h40000);
		wr(`OFS_CLOCK_CTRL, 8'h00);
		wr(`OFS_CONTROL, 8'h82);
		run(80);
		near("carry", carry_cnt, 20, 1);
		near("duty", high_cnt, 40, 2);
		check("pin on", {31'h0, synth_pin_out}, {31'h0, synth_output_out});
		wr(`OFS_INC_UPPER, 8'h08);
		run(80);
		near("held", carry_cnt, 20, 1);
		wr(`OFS_INC_HIGH, 8'h00);
		wr(`OFS_INC_LOW, 8'h00);
		run(80);
		near("loaded", carry_cnt, 40, 2);
		set_inc(20'h30000);
		run(160);
		near("wrap", carry_cnt, 30, 2);
		set_inc(20'h10000);
		for (int s = 0; s < 4; s++)
		begin
			wr(`OFS_CLOCK_CTRL, 8'(s << 5));
			wr(`OFS_CONTROL, 8'h81);
			run(160);
			near("width", high_cnt, 10 << s, (1 << s) + 1);
		end
		wr(`OFS_CLOCK_CTRL, 8'h00);
		wr(`OFS_CONTROL, 8'h91);
		run(160);
		near("invert", high_cnt, 150, 2);
		check("pin off", {31'h0, synth_pin_out}, 32'h0);
		wr(`OFS_IRQ_EN, 8'h01);
		irq_is(1'b0);
		rd(`OFS_IRQ_REQ, 8'h01);
		wr(`OFS_IRQ_GLOBAL, 8'h03);
		irq_is(1'b1);
		wr(`OFS_IRQ_GLOBAL, 8'h01);
		irq_is(1'b0);
		wr(`OFS_IRQ_GLOBAL, 8'h03);
		wr(`OFS_CONTROL, 8'h00);
		irq_is(1'b0);
		rd(`OFS_IRQ_REQ, 8'h01);
		wr(`OFS_IRQ_REQ, 8'h00);
		rd(`OFS_IRQ_REQ, 8'h00);
		set_inc(20'h00000);
		wr(`OFS_CONTROL, 8'h81);
		wr(`OFS_IRQ_REQ, 8'h00);
		rd(`OFS_IRQ_REQ, 8'h00);
		wr(`OFS_CONTROL, 8'h91);
		rd(`OFS_IRQ_REQ, 8'h01);
		set_inc(20'h40000);
		wr(`OFS_CONTROL, 8'h80);
		for (int c = 0; c < 8; c++)
		begin
			wr(`OFS_CLOCK_CTRL, c[7:0]);
			run(480);
			near("rate", carry_cnt, rate_exp[c], 2);
			check("awake", {31'h0, hf_oscillator_keep_awake_out}, c == 1);
		end
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		@(posedge core_clk_in);
		reset_in <= 1'b0;
		rd(`OFS_CONTROL, 8'h00);
		stop_test();
	end
endmodule // tb_numerically_controlled_oscillator
bind numerically_controlled_oscillator nco_monitor nco_monitor_i (.core_clk_in, .reset_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
	.synth_output_out, .synth_pin_out, .accumulator_carry_out, .irq_out,
	.hf_oscillator_keep_awake_out);
